// ---- scc_bus_cycle.sv ----
// Purpose: one asynchronous write or read cycle on the flash bus
// Assumes: strobes active low, phase length from the package
// Notes: read data captured just before the strobes rise
`timescale 1ns/1ps
module scc_bus_cycle
  import scc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic start,
  input wire logic is_read,
  input wire logic [SCC_ADDR_W-1:0] addr,
  input wire logic [SCC_DATA_W-1:0] wdata,
  output logic done,
  output logic [SCC_DATA_W-1:0] rdata,
  // flash pins
  input wire logic [SCC_DATA_W-1:0] dq_in,
  output logic [SCC_ADDR_W-1:0] fa,
  output logic [SCC_DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  typedef enum logic [1:0] {SCC_C_IDLE, SCC_C_SETUP, SCC_C_STROBE,
    SCC_C_HOLD} scc_cyc_e;
  scc_cyc_e st, next_st;
  logic [7:0] cnt, next_cnt;
  logic rd, next_rd;
  logic [SCC_ADDR_W-1:0] next_fa;
  logic [SCC_DATA_W-1:0] next_dq_out, next_rdata, dq_s1, dq_s2;
  logic next_dq_oe, next_ce_n, next_oe_n, next_we_n, next_done;

  always_comb
  begin
    next_st = st;
    next_cnt = cnt;
    next_rd = rd;
    next_fa = fa;
    next_dq_out = dq_out;
    next_dq_oe = dq_oe;
    next_ce_n = ce_n;
    next_oe_n = oe_n;
    next_we_n = we_n;
    next_rdata = rdata;
    next_done = 1'b0;
    case (st)
      SCC_C_IDLE:
      begin
        if (start)
        begin
          next_st = SCC_C_SETUP;
          next_rd = is_read;
          next_fa = addr;
          next_dq_out = wdata;
          next_dq_oe = !is_read;
          next_cnt = 8'(SCC_PHASE_CYC);
        end
      end
      SCC_C_SETUP:
      begin
        next_ce_n = 1'b0;
        next_oe_n = !rd;
        next_we_n = rd;
        next_st = SCC_C_STROBE;
      end
      SCC_C_STROBE:
      begin
        if (cnt == 8'h00)
        begin
          next_rdata = dq_s2;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_we_n = 1'b1;
          next_st = SCC_C_HOLD;
          next_cnt = 8'(SCC_PHASE_CYC);
        end
        else
          next_cnt = cnt - 8'h01;
      end
      SCC_C_HOLD:
      begin
        if (cnt == 8'h00)
        begin
          next_dq_oe = 1'b0;
          next_done = 1'b1;
          next_st = SCC_C_IDLE;
        end
        else
          next_cnt = cnt - 8'h01;
      end
      default:
        next_st = SCC_C_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= SCC_C_IDLE;
      cnt <= 8'h00;
      rd <= 1'b0;
      fa <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      rdata <= '0;
      done <= 1'b0;
      dq_s1 <= '0;
      dq_s2 <= '0;
    end
    else
    begin
      st <= next_st;
      cnt <= next_cnt;
      rd <= next_rd;
      fa <= next_fa;
      dq_out <= next_dq_out;
      dq_oe <= next_dq_oe;
      ce_n <= next_ce_n;
      oe_n <= next_oe_n;
      we_n <= next_we_n;
      rdata <= next_rdata;
      done <= next_done;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end
endmodule

// ---- scc_ctrl.sv ----
// Purpose: host controller for status read and continuity check of a flash
// Assumes: flash keeps its own status register and overlay logic
// Notes: one sequence at a time; byte_mode selects x8 addresses
// Function
// - host clears status, issues status read, checks bit 0 is zero.
// - x16 pattern writes 2AAAA55h/FF00h then 15555AAh/00FFh.
// - x8 uses setup address AAAh, pattern 55554ABh/FFh, 2AAAB54h/00h.
// - host re-reads status after pattern; bit 0 one means continuity.
// - host masks the upper status byte.
// - bit 7 one means idle; bits 6..1 valid only then.
`timescale 1ns/1ps
module scc_ctrl
  import scc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user orders
  input wire logic go_status,
  input wire logic go_check,
  input wire logic byte_mode,
  input wire logic die_sel,
  output logic busy,
  output logic done,
  output logic [7:0] status,
  output logic status_ready,
  output logic pass,
  output logic fail,
  // flash pins
  input wire logic [SCC_DATA_W-1:0] dq_in,
  output logic [SCC_ADDR_W-1:0] fa,
  output logic [SCC_DATA_W-1:0] dq_out,
  output logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n
);
  typedef enum logic [3:0] {SCC_IDLE, SCC_CLR, SCC_SR1, SCC_RD1, SCC_PAT1,
    SCC_PAT2, SCC_SR2, SCC_RD2, SCC_SRS, SCC_RDS, SCC_END} scc_st_e;
  scc_st_e st, next_st;
  logic issued, next_issued;
  logic mode, next_mode, die, next_die;
  logic next_busy, next_done, next_pass;
  logic next_fail, next_status_ready;
  logic [7:0] next_status;
  logic cyc_start, cyc_read, cyc_done;
  logic [SCC_ADDR_W-1:0] cyc_addr;
  logic [SCC_DATA_W-1:0] cyc_wdata, cyc_rdata;

  function automatic logic [SCC_ADDR_W-1:0] with_die(
    input logic [SCC_ADDR_W-1:0] a, input logic bm, input logic d);
    logic [SCC_ADDR_W-1:0] r;
    r = a;
    // die select on top address line
    if (bm)
      r[SCC_B_DIE_BIT] = d;
    else
      r[SCC_W_DIE_BIT] = d;
    return r;
  endfunction

  function automatic logic [SCC_ADDR_W-1:0] cmd_addr(input logic bm);
    return bm ? SCC_B_CMD_ADDR : SCC_W_CMD_ADDR;
  endfunction

  assign cyc_start = (st != SCC_IDLE) && (st != SCC_END) && !issued;
  assign cyc_read = (st == SCC_RD1) || (st == SCC_RD2) || (st == SCC_RDS);

  always_comb
  begin
    cyc_addr = with_die(cmd_addr(mode), mode, die);
    cyc_wdata = {8'h00, SCC_CMD_STATUS};
    case (st)
      SCC_CLR: cyc_wdata = {8'h00, SCC_CMD_CLEAR};
      SCC_PAT1:
      begin
        cyc_addr = with_die(mode ? SCC_B_PAT1_ADDR : SCC_W_PAT1_ADDR,
          mode, die);
        cyc_wdata = mode ? SCC_B_PAT1_DATA : SCC_W_PAT1_DATA;
      end
      SCC_PAT2:
      begin
        cyc_addr = with_die(mode ? SCC_B_PAT2_ADDR : SCC_W_PAT2_ADDR,
          mode, die);
        cyc_wdata = mode ? SCC_B_PAT2_DATA : SCC_W_PAT2_DATA;
      end
      default:
        cyc_addr = with_die(cmd_addr(mode), mode, die);
    endcase
  end

  always_comb
  begin
    next_st = st;
    next_issued = issued;
    next_mode = mode;
    next_die = die;
    next_busy = busy;
    next_done = 1'b0;
    next_pass = pass;
    next_fail = fail;
    next_status = status;
    next_status_ready = status_ready;
    if (cyc_start)
      next_issued = 1'b1;
    case (st)
      SCC_IDLE:
      begin
        if (go_check || go_status)
        begin
          next_mode = byte_mode;
          next_die = die_sel;
          next_busy = 1'b1;
          next_pass = 1'b0;
          next_fail = 1'b0;
          next_status_ready = 1'b0;
          next_st = go_check ? SCC_CLR : SCC_SRS;
        end
      end
      SCC_END:
      begin
        next_busy = 1'b0;
        next_done = 1'b1;
        next_st = SCC_IDLE;
      end
      default:
      begin
        if (cyc_done)
        begin
          next_issued = 1'b0;
          case (st)
            SCC_CLR: next_st = SCC_SR1;
            SCC_SR1: next_st = SCC_RD1;
            SCC_RD1:
            begin
              next_status = cyc_rdata[7:0] & SCC_LOW_MASK;
              next_st = cyc_rdata[SCC_BIT_CONT] ? SCC_END : SCC_PAT1;
              next_fail = cyc_rdata[SCC_BIT_CONT];
            end
            SCC_PAT1: next_st = SCC_PAT2;
            SCC_PAT2: next_st = SCC_SR2;
            SCC_SR2: next_st = SCC_RD2;
            SCC_RD2:
            begin
              next_status = cyc_rdata[7:0] & SCC_LOW_MASK;
              next_status_ready = 1'b1;
              next_pass = cyc_rdata[SCC_BIT_CONT];
              next_fail = !cyc_rdata[SCC_BIT_CONT];
              next_st = SCC_END;
            end
            SCC_SRS: next_st = SCC_RDS;
            SCC_RDS:
            begin
              next_status = cyc_rdata[7:0] & SCC_LOW_MASK;
              // other bits valid only when ready
              next_status_ready = cyc_rdata[SCC_BIT_READY];
              next_st = SCC_END;
            end
            default: next_st = SCC_END;
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st <= SCC_IDLE;
      issued <= 1'b0;
      mode <= 1'b0;
      die <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pass <= 1'b0;
      fail <= 1'b0;
      status <= 8'h00;
      status_ready <= 1'b0;
    end
    else
    begin
      st <= next_st;
      issued <= next_issued;
      mode <= next_mode;
      die <= next_die;
      busy <= next_busy;
      done <= next_done;
      pass <= next_pass;
      fail <= next_fail;
      status <= next_status;
      status_ready <= next_status_ready;
    end
  end

  scc_bus_cycle u_cyc (
    .clk(clk),
    .rst(rst),
    .start(cyc_start),
    .is_read(cyc_read),
    .addr(cyc_addr),
    .wdata(cyc_wdata),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .dq_in(dq_in),
    .fa(fa),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .ce_n(ce_n),
    .oe_n(oe_n),
    .we_n(we_n)
  );
endmodule

// ---- scc_ctrl_properties.sv ----
// Purpose: port checks for the flash status and continuity controller
// Assumes: one clock, synchronous active high reset
// Notes: bound to scc_ctrl below
`timescale 1ns/1ps
module scc_ctrl_checker
  import scc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // user side
  input wire logic go_status,
  input wire logic go_check,
  input wire logic busy,
  input wire logic done,
  input wire logic pass,
  input wire logic fail,
  // flash pins
  input wire logic [SCC_ADDR_W-1:0] fa,
  input wire logic [SCC_DATA_W-1:0] dq_out,
  input wire logic dq_oe,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence we_held;
    !we_n [*6];
  endsequence
  sequence oe_held;
    !oe_n [*6];
  endsequence
  sequence taken;
    !busy && !done && (go_check || go_status);
  endsequence
  reset_idle_a: assert property (disable iff (1'b0)
    rst |=> ce_n && we_n && oe_n && !dq_oe && !busy && !done)
    else $error("outputs not idle after reset");
  cmd_data_a: assert property (!we_n
    && (fa[25:0] == SCC_W_CMD_ADDR[25:0]
    || fa[25:0] == SCC_B_CMD_ADDR[25:0]) |-> dq_out[7:0] == SCC_CMD_CLEAR
    || dq_out[7:0] == SCC_CMD_STATUS) else $error("bad command data");
  word_first_a: assert property (!we_n
    && fa[25:0] == SCC_W_PAT1_ADDR[25:0] |-> dq_out == SCC_W_PAT1_DATA)
    else $error("bad first word pattern");
  word_second_a: assert property (!we_n
    && fa[25:0] == SCC_W_PAT2_ADDR[25:0] |-> dq_out == SCC_W_PAT2_DATA)
    else $error("bad second word pattern");
  byte_first_a: assert property (!we_n
    && fa[26:0] == SCC_B_PAT1_ADDR[26:0]
    |-> dq_out[7:0] == SCC_B_PAT1_DATA[7:0]) else $error("bad byte pattern");
  byte_second_a: assert property (!we_n
    && fa[26:0] == SCC_B_PAT2_ADDR[26:0]
    |-> dq_out[7:0] == SCC_B_PAT2_DATA[7:0]) else $error("bad byte inverse");
  write_drive_a: assert property (!we_n |-> dq_oe && !ce_n && oe_n)
    else $error("write strobe without drive");
  read_release_a: assert property (!oe_n
    |-> !dq_oe && !ce_n && we_n) else $error("read strobe while driving");
  write_width_a: assert property ($fell(we_n) |-> we_held)
    else $error("write strobe too short");
  read_width_a: assert property ($fell(oe_n) |-> oe_held)
    else $error("read strobe too short");
  write_stable_a: assert property (!we_n && !$fell(we_n)
    |-> $stable(fa) && $stable(dq_out)) else $error("write data moved");
  verdict_excl_a: assert property (!(pass && fail))
    else $error("pass and fail together");
  check_bound_a: assert property (taken and go_check
    |-> ##[40:400] done) else $error("check did not finish");
  status_bound_a: assert property (taken and !go_check
    |-> ##[20:100] done) else $error("status order did not finish");
  // a new order may be taken in the done cycle, so busy may rise after it
  done_pulse_a: assert property (done |-> !busy ##1 !done)
    else $error("done longer than one cycle");
endmodule
bind scc_ctrl scc_ctrl_checker u_scc_ctrl_checker(.clk(clk), .rst(rst),
  .go_status(go_status), .go_check(go_check), .busy(busy), .done(done),
  .pass(pass), .fail(fail), .fa(fa), .dq_out(dq_out), .dq_oe(dq_oe),
  .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));

// ---- scc_flash_model.sv ----
// Purpose: behavioural flash die with status overlay and continuity check
// Assumes: strobe edges seen on the controller clock
// Notes: link_ok low breaks the pattern; unselected die leaves bus noisy
`timescale 1ns/1ps
module scc_flash_model
  import scc_pkg::*;
#(parameter bit DIE = 1'b0)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // bench controls
  input wire logic byte_mode,
  input wire logic link_ok,
  input wire logic ea_busy,
  // flash pins
  input wire logic [SCC_ADDR_W-1:0] fa,
  input wire logic [SCC_DATA_W-1:0] dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  output logic [SCC_DATA_W-1:0] dq
);
  logic [7:0] sr, lat;
  logic ovl, pv, pwe, prd, sel, hit;
  logic [27:0] pa, m;
  logic [15:0] pd, junk;
  // arbitrary soft reset command code
  localparam logic [7:0] SOFT_RST_CMD = 8'hF0;
  assign sel = (byte_mode ? fa[SCC_B_DIE_BIT] : fa[SCC_W_DIE_BIT]) == DIE;
  assign m = byte_mode ? 28'h7FFFFFF : 28'h3FFFFFF;
  assign hit = pv && link_ok && (((pa ^ fa) & m) == m)
    && (((pd ^ dq_out) | (byte_mode ? 16'hFF00 : 16'h0000)) == 16'hFFFF);
  assign dq = (sel && !ce_n && !oe_n && ovl && !(byte_mode && fa[0]))
    ? {junk[15:8], lat} : junk;
  always_ff @(posedge clk)
  begin
    junk <= 16'($urandom);
    pwe <= we_n;
    prd <= oe_n | ce_n;
    if (rst)
    begin
      sr <= 8'h80;
      lat <= 8'h80;
      ovl <= 1'b0;
      pv <= 1'b0;
    end
    else
    begin
      sr[7] <= !ea_busy;
      if (we_n && !pwe && sel && !ovl)
      begin
        pa <= fa;
        pd <= dq_out;
        pv <= 1'b1;
        if (dq_out[7:0] == SCC_CMD_STATUS)
        begin
          lat <= {!ea_busy, sr[6:0]};
          ovl <= 1'b1;
        end
        if (dq_out[7:0] == SCC_CMD_CLEAR)
          sr[5:0] <= sr[5:0] & 6'h04;
        if (dq_out[7:0] == SOFT_RST_CMD && !sr[3])
          sr[5:0] <= sr[5:0] & 6'h0C;
        if (hit)
          sr[0] <= 1'b1;
      end
      if (sel && (oe_n | ce_n) && !prd)
        ovl <= 1'b0;
    end
  end
endmodule

// ---- scc_pkg.sv ----
// Purpose: constants for the flash status and continuity controller
// Assumes: asynchronous flash bus, 100 MHz controller clock
// Notes: the addresses are word addresses in x16 and byte addresses in x8
package scc_pkg;
  localparam int SCC_ADDR_W = 28;
  localparam int SCC_DATA_W = 16;
  localparam int SCC_CLK_MHZ = 100;
  // strobe phase time in ns
  localparam int SCC_PHASE_NS = 60;
  localparam int SCC_PHASE_CYC = (SCC_PHASE_NS * SCC_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] SCC_CMD_CLEAR = 8'h71;
  localparam logic [7:0] SCC_CMD_STATUS = 8'h70;
  localparam logic [27:0] SCC_W_CMD_ADDR = 28'h0000555;
  localparam logic [27:0] SCC_B_CMD_ADDR = 28'h0000AAA;
  localparam logic [27:0] SCC_W_PAT1_ADDR = 28'h2AAAA55;
  localparam logic [27:0] SCC_W_PAT2_ADDR = 28'h15555AA;
  localparam logic [15:0] SCC_W_PAT1_DATA = 16'hFF00;
  localparam logic [15:0] SCC_W_PAT2_DATA = 16'h00FF;
  localparam logic [27:0] SCC_B_PAT1_ADDR = 28'h55554AB;
  localparam logic [27:0] SCC_B_PAT2_ADDR = 28'h2AAAB54;
  localparam logic [15:0] SCC_B_PAT1_DATA = 16'h00FF;
  localparam logic [15:0] SCC_B_PAT2_DATA = 16'h0000;
  // die select position in word and in byte address
  localparam int SCC_W_DIE_BIT = 26;
  localparam int SCC_B_DIE_BIT = 27;
  localparam int SCC_BIT_READY = 7;
  localparam int SCC_BIT_CONT = 0;
  localparam logic [7:0] SCC_LOW_MASK = 8'hFF;
  typedef enum logic [1:0] {SCC_OP_WRITE, SCC_OP_READ} scc_op_e;
endpackage

// ---- tb_top.sv ----
// Purpose: random and corner tests of the status and continuity controller
// Assumes: two flash dies share the bus, selected by the die address bit
// Notes: expected flags per die are tracked in cc
`timescale 1ns/1ps
module tb_top;
  import scc_pkg::*;
  logic clk = 0, rst = 1, go_status = 0, go_check = 0;
  logic byte_mode = 0, die_sel = 0, link_ok = 1, ea_busy = 0;
  logic busy, done, status_ready, pass, fail, dq_oe, ce_n, oe_n, we_n;
  logic [7:0] status;
  logic [1:0] cc;
  logic [SCC_ADDR_W-1:0] fa;
  logic [SCC_DATA_W-1:0] dq_out, dq_in, dq0, dq1;
  int num_errors = 0, n_compared = 0, cyc = 0;
  assign dq_in = (byte_mode ? fa[SCC_B_DIE_BIT] : fa[SCC_W_DIE_BIT])
    ? dq1 : dq0;
  initial forever #5 clk = ~clk;
  scc_ctrl u_scc_ctrl(.clk(clk), .rst(rst), .go_status(go_status),
    .go_check(go_check), .byte_mode(byte_mode), .die_sel(die_sel),
    .busy(busy), .done(done), .status(status), .status_ready(status_ready),
    .pass(pass), .fail(fail), .dq_in(dq_in), .fa(fa), .dq_out(dq_out),
    .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));
  scc_flash_model #(.DIE(1'b0)) u_die0(.clk(clk), .rst(rst),
    .byte_mode(byte_mode), .link_ok(link_ok), .ea_busy(ea_busy), .fa(fa),
    .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq0));
  scc_flash_model #(.DIE(1'b1)) u_die1(.clk(clk), .rst(rst),
    .byte_mode(byte_mode), .link_ok(link_ok), .ea_busy(ea_busy), .fa(fa),
    .dq_out(dq_out), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq(dq1));
  // low status byte: ready bit on top, continuity flag at the bottom
  function automatic logic [7:0] exp_status(input logic rdy,
    input logic cont);
    return {rdy, 6'h00, cont};
  endfunction
  task automatic cmp(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic order(input logic chk);
    int n;
    n = 0;
    go_check = chk;
    go_status = !chk;
    @(posedge clk);
    #1;
    go_check = 0;
    go_status = 0;
    while (done !== 1'b1 && n < 500)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 500)
      num_errors++;
  endtask
  task print_verdict;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    logic op;
    void'($urandom(32'h6BF2E847));
    cc = 2'h0;
    repeat (12) @(posedge clk);
    #1;
    rst = 0;
    order(1'b0);
    cmp(status, exp_status(1'b1, 1'b0));
    for (int i = 0; i < 24; i++)
    begin
      byte_mode = i < 8 ? i[0] : 1'($urandom);
      die_sel = i < 8 ? i[1] : 1'($urandom);
      link_ok = i < 4 ? 1'b1 : 1'($urandom % 4 != 0);
      op = i < 4 ? 1'b1 : i < 8 ? 1'b0 : 1'($urandom);
      if (op)
      begin
        order(1'b1);
        cc[die_sel] = link_ok;
        cmp(8'(pass), 8'(link_ok));
        cmp(8'(fail), 8'(!link_ok));
        cmp(status, exp_status(1'b1, link_ok));
        cmp(8'(status_ready), 8'h01);
      end
      else
      begin
        ea_busy = 1'($urandom);
        order(1'b0);
        cmp(status, exp_status(!ea_busy, cc[die_sel]));
        cmp(8'(status_ready), 8'(!ea_busy));
        ea_busy = 0;
      end
      repeat ($urandom % 3) @(posedge clk);
      #1;
    end
    print_verdict;
  end
endmodule
